// ---- src/ipr_pkg.sv ----
// Package with the layout, reset values and carriers of the priority bank.
package ipr_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int NUM_REGS  = 7;
	localparam int NUM_SRC   = 15;
	localparam int FLD_W     = 3;
	localparam int REG_W     = 16;
	localparam int DATA_W    = 32;
	localparam int BE_W      = DATA_W / 8;
	localparam int AV_ADDR_W = 5;

	typedef logic [REG_W-1:0]     ipr_word_t;
	typedef logic [AV_ADDR_W-1:0] ipr_addr_t;
	typedef logic [FLD_W-1:0]     ipr_fld_t;

	// ************************************************************
	// Register map, one aligned 32-bit word per register
	// ************************************************************
	localparam ipr_addr_t OFF_PRIO_5  = 5'h00;
	localparam ipr_addr_t OFF_PRIO_6  = 5'h04;
	localparam ipr_addr_t OFF_PRIO_7  = 5'h08;
	localparam ipr_addr_t OFF_PRIO_8  = 5'h0c;
	localparam ipr_addr_t OFF_PRIO_9  = 5'h10;
	localparam ipr_addr_t OFF_PRIO_10 = 5'h14;
	localparam ipr_addr_t OFF_PRIO_11 = 5'h18;

	localparam ipr_addr_t REG_OFF [NUM_REGS] = '{
		OFF_PRIO_5, OFF_PRIO_6, OFF_PRIO_7, OFF_PRIO_8,
		OFF_PRIO_9, OFF_PRIO_10, OFF_PRIO_11
	};

	// Implemented bits of each register; all others read as zero.
	localparam ipr_word_t REG_MASK [NUM_REGS] = '{
		16'h0007,
		16'h7770,
		16'h7777,
		16'h0077,
		16'h7770,
		16'h0070,
		16'h0070
	};

	// Every field wakes up at level four, pattern 100.
	localparam ipr_word_t PRIO_RESET_PATTERN = 16'h4444;
	localparam logic [NUM_SRC-1:0] SRC_ACTIVE_RESET = 15'h7fff;

	// ************************************************************
	// Field positions, source index to register and low bit
	// ************************************************************
	localparam int FLD_HI  = 12;
	localparam int FLD_MID = 8;
	localparam int FLD_LOW = 4;
	localparam int FLD_BOT = 0;

	localparam int SRC_REG [NUM_SRC] = '{
		0,
		1,
		1,
		1,
		2,
		2,
		2,
		2,
		3,
		3,
		4,
		4,
		4,
		5,
		6
	};

	localparam int SRC_LSB [NUM_SRC] = '{
		FLD_BOT, FLD_HI, FLD_MID, FLD_LOW, FLD_HI, FLD_MID, FLD_LOW,
		FLD_BOT, FLD_LOW, FLD_BOT, FLD_HI, FLD_MID, FLD_LOW, FLD_LOW,
		FLD_LOW
	};

	// ************************************************************
	// Carriers
	// ************************************************************
	// Last member is source 0, so source s sits at bits s*3 upward.
	typedef struct packed {
		ipr_fld_t parallel_port_prio;
		ipr_fld_t out_cmp_five_prio;
		ipr_fld_t in_cap_three_prio;
		ipr_fld_t in_cap_four_prio;
		ipr_fld_t in_cap_five_prio;
		ipr_fld_t spi_b_fault_prio;
		ipr_fld_t spi_b_event_prio;
		ipr_fld_t timer_five_prio;
		ipr_fld_t ext_irq2_prio;
		ipr_fld_t uart_b_rx_prio;
		ipr_fld_t uart_b_tx_prio;
		ipr_fld_t out_cmp_three_prio;
		ipr_fld_t out_cmp_four_prio;
		ipr_fld_t timer_four_prio;
		ipr_fld_t ext_irq1_prio;
	} ipr_prio_t;

	typedef struct packed {
		logic       hit;
		logic [2:0] idx;
	} ipr_dec_t;

	localparam ipr_fld_t PRIO_OFF  = 3'h0;
	localparam ipr_fld_t PRIO_TOP  = 3'h7;

endpackage

// ---- src/ipr_regs.sv ----
// Interrupt priority register bank behind an Avalon-MM slave.
//
// Contract
// - Field value is the priority level directly.
// - Field value zero disables that source.
// - Every field resets to level four.
// - Unassigned bits ignore writes, read zero.
// - Fifth register: external irq one, bits 2-0.
// - Sixth register: timer four, bits 14-12.
// - Sixth register: compare four, bits 10-8.
// - Sixth register: compare three, bits 6-4.
// - Seventh register: second uart tx, 14-12.
// - Seventh register: second uart rx, 10-8.
// - Seventh register: external irq two, 6-4.
// - Seventh register: timer five, bits 2-0.
// - Eighth register: second spi event, 6-4.
// - Eighth register: second spi fault, 2-0.
// - Ninth register: capture five, bits 14-12.
// - Ninth register: capture four, bits 10-8.
// - Ninth register: capture three, bits 6-4.
// - Tenth register: compare five, bits 6-4.
// - Eleventh register: parallel port, bits 6-4.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps

module ipr_regs
	import ipr_pkg::*;
(
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire logic [AV_ADDR_W-1:0] i_avs_address,
	input  wire logic                 i_avs_read,
	input  wire logic                 i_avs_write,
	input  wire logic [DATA_W-1:0]    i_avs_writedata,
	input  wire logic [BE_W-1:0]      i_avs_byteenable,
	output logic      [DATA_W-1:0]    o_avs_readdata,
	output logic                      o_avs_waitrequest,
	output ipr_prio_t                 o_prio,
	output logic      [NUM_SRC-1:0]   o_src_active
);

	// ************************************************************
	// Address decode
	// ************************************************************
	function automatic ipr_dec_t decode(input ipr_addr_t a);
		ipr_dec_t d;
		d = '0;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (a == REG_OFF[i]) begin
				d.hit = 1'b1;
				d.idx = 3'(i);
			end
		end
		return d;
	endfunction

	ipr_dec_t                 dec;
	logic                     req;
	logic                     wr_fire;
	ipr_word_t                lane_mask;
	ipr_word_t                prio_reg  [NUM_REGS];
	ipr_word_t                next_prio [NUM_REGS];
	logic [NUM_SRC*FLD_W-1:0] prio_vec;

	assign dec       = decode(i_avs_address);
	assign req       = i_avs_read | i_avs_write;
	// A write lands only on the edge where waitrequest is seen low.
	assign wr_fire   = i_avs_write & ~o_avs_waitrequest;
	assign lane_mask = {{8{i_avs_byteenable[1]}},
		{8{i_avs_byteenable[0]}}};

	// ************************************************************
	// Bus handshake
	// ************************************************************
	// One wait cycle per access keeps read data straight from a flop.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_avs_waitrequest <= 1'b1;
		end else if (req && o_avs_waitrequest) begin
			o_avs_waitrequest <= 1'b0;
		end else begin
			o_avs_waitrequest <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_avs_readdata <= '0;
		end else if (i_avs_read && o_avs_waitrequest) begin
			if (dec.hit) begin
				o_avs_readdata <= DATA_W'(prio_reg[dec.idx]);
			end else begin
				o_avs_readdata <= '0;
			end
		end
	end

	// ************************************************************
	// Priority storage
	// ************************************************************
	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			next_prio[i] = prio_reg[i];
			if (wr_fire && dec.hit && dec.idx == 3'(i)) begin
				// Masked merge drops writes to unassigned bits.
				next_prio[i] = (prio_reg[i]
					& ~(REG_MASK[i] & lane_mask))
					| (i_avs_writedata[REG_W-1:0]
					& REG_MASK[i] & lane_mask);
			end
		end
	end

	generate
		for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					prio_reg[g] <= REG_MASK[g] & PRIO_RESET_PATTERN;
				end else begin
					prio_reg[g] <= next_prio[g];
				end
			end

			reset_level_a: assert property (@(posedge i_clk)
				$past(i_rst) |->
				prio_reg[g] == (REG_MASK[g] & PRIO_RESET_PATTERN))
				else $error("priority register missed reset value");

			unimpl_zero_a: assert property (@(posedge i_clk)
				disable iff (i_rst)
				(prio_reg[g] & ~REG_MASK[g]) == '0)
				else $error("unassigned bit became set");

			write_land_a: assert property (@(posedge i_clk)
				disable iff (i_rst)
				wr_fire && dec.hit && dec.idx == 3'(g)
				&& i_avs_byteenable[1:0] == 2'b11 |=>
				prio_reg[g] == ($past(i_avs_writedata[REG_W-1:0])
				& REG_MASK[g]))
				else $error("write did not land in register");

			hold_idle_a: assert property (@(posedge i_clk)
				disable iff (i_rst)
				!(wr_fire && dec.hit && dec.idx == 3'(g)) |=>
				$stable(prio_reg[g]))
				else $error("register changed without a write");

			// Software may update one byte of a register on its own.
			lane_keep_a: assert property (@(posedge i_clk)
				disable iff (i_rst)
				wr_fire && dec.hit && dec.idx == 3'(g) |=>
				((prio_reg[g] ^ $past(prio_reg[g]))
				& ~$past(lane_mask)) == '0)
				else $error("write touched a disabled lane");
		end
	endgenerate

	// ************************************************************
	// Per-source outputs
	// ************************************************************
	always_comb begin
		prio_vec = '0;
		for (int s = 0; s < NUM_SRC; s++) begin
			prio_vec[s*FLD_W +: FLD_W] =
				prio_reg[SRC_REG[s]][SRC_LSB[s] +: FLD_W];
		end
	end

	// The level passes through unchanged; arbitration ranks it.
	assign o_prio = ipr_prio_t'(prio_vec);

	generate
		for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					o_src_active[s] <= SRC_ACTIVE_RESET[s];
				end else begin
					o_src_active[s] <= next_prio[SRC_REG[s]]
						[SRC_LSB[s] +: FLD_W] != PRIO_OFF;
				end
			end

			src_gate_a: assert property (@(posedge i_clk)
				disable iff (i_rst)
				o_src_active[s] == (prio_vec[s*FLD_W +: FLD_W]
				!= PRIO_OFF))
				else $error("source enable disagrees with level");
		end
	endgenerate

	// ************************************************************
	// Bus and field checks
	// ************************************************************
	wait_once_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		req && o_avs_waitrequest |=> !o_avs_waitrequest ##1
		o_avs_waitrequest)
		else $error("waitrequest not a single low cycle");

	read_match_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		i_avs_read && !o_avs_waitrequest && dec.hit |->
		o_avs_readdata == DATA_W'(prio_reg[dec.idx]))
		else $error("read data differs from register");

	read_unmap_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		i_avs_read && !o_avs_waitrequest && !dec.hit |->
		o_avs_readdata == '0)
		else $error("unmapped read not zero");

	ext1_top_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_5
		&& i_avs_byteenable[0]
		&& i_avs_writedata[2:0] == PRIO_TOP |=>
		o_prio.ext_irq1_prio == PRIO_TOP && o_src_active[0])
		else $error("external irq one level not taken");

	timer4_pos_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		o_prio.timer_four_prio == prio_reg[1][14:12]
		&& o_prio.uart_b_tx_prio == prio_reg[2][14:12]
		&& o_prio.spi_b_fault_prio == prio_reg[3][2:0]
		&& o_prio.parallel_port_prio == prio_reg[6][6:4])
		else $error("field sits at the wrong bits");

	off_write_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_8
		&& i_avs_byteenable[0]
		&& i_avs_writedata[6:4] == PRIO_OFF |=>
		!o_src_active[8] ##1 !o_src_active[8] || wr_fire)
		else $error("disabled source still enabled");

	read_upper_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		o_avs_readdata[DATA_W-1:REG_W] == '0)
		else $error("read data upper half not zero");

	// Read data must stand until the next read is taken.
	read_hold_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		!(i_avs_read && o_avs_waitrequest) |=>
		$stable(o_avs_readdata))
		else $error("read data moved without a read");

	wait_reset_a: assert property (@(posedge i_clk)
		$past(i_rst) |->
		o_avs_waitrequest && o_avs_readdata == '0)
		else $error("bus outputs not at reset values");

	src_reset_a: assert property (@(posedge i_clk)
		$past(i_rst) |-> &o_src_active)
		else $error("a source came out of reset disabled");

	// ************************************************************
	// Field placement checks
	// ************************************************************
	// Each check names the struct member and the offset on its own, so a
	// slip in the shared source tables cannot hide behind them.
	ext1_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_5
		&& lane_mask[FLD_BOT] |=>
		o_prio.ext_irq1_prio
		== $past(i_avs_writedata[FLD_BOT +: FLD_W]))
		else $error("external irq one field misplaced");

	tmr4_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_6
		&& lane_mask[FLD_HI] |=>
		o_prio.timer_four_prio
		== $past(i_avs_writedata[FLD_HI +: FLD_W]))
		else $error("timer four field misplaced");

	cmp4_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_6
		&& lane_mask[FLD_MID] |=>
		o_prio.out_cmp_four_prio
		== $past(i_avs_writedata[FLD_MID +: FLD_W]))
		else $error("compare four field misplaced");

	cmp3_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_6
		&& lane_mask[FLD_LOW] |=>
		o_prio.out_cmp_three_prio
		== $past(i_avs_writedata[FLD_LOW +: FLD_W]))
		else $error("compare three field misplaced");

	utx_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_7
		&& lane_mask[FLD_HI] |=>
		o_prio.uart_b_tx_prio
		== $past(i_avs_writedata[FLD_HI +: FLD_W]))
		else $error("uart transmit field misplaced");

	urx_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_7
		&& lane_mask[FLD_MID] |=>
		o_prio.uart_b_rx_prio
		== $past(i_avs_writedata[FLD_MID +: FLD_W]))
		else $error("uart receive field misplaced");

	ext2_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_7
		&& lane_mask[FLD_LOW] |=>
		o_prio.ext_irq2_prio
		== $past(i_avs_writedata[FLD_LOW +: FLD_W]))
		else $error("external irq two field misplaced");

	tmr5_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_7
		&& lane_mask[FLD_BOT] |=>
		o_prio.timer_five_prio
		== $past(i_avs_writedata[FLD_BOT +: FLD_W]))
		else $error("timer five field misplaced");

	spi_event_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_8
		&& lane_mask[FLD_LOW] |=>
		o_prio.spi_b_event_prio
		== $past(i_avs_writedata[FLD_LOW +: FLD_W]))
		else $error("spi event field misplaced");

	spi_fault_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_8
		&& lane_mask[FLD_BOT] |=>
		o_prio.spi_b_fault_prio
		== $past(i_avs_writedata[FLD_BOT +: FLD_W]))
		else $error("spi fault field misplaced");

	cap5_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_9
		&& lane_mask[FLD_HI] |=>
		o_prio.in_cap_five_prio
		== $past(i_avs_writedata[FLD_HI +: FLD_W]))
		else $error("capture five field misplaced");

	cap4_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_9
		&& lane_mask[FLD_MID] |=>
		o_prio.in_cap_four_prio
		== $past(i_avs_writedata[FLD_MID +: FLD_W]))
		else $error("capture four field misplaced");

	cap3_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_9
		&& lane_mask[FLD_LOW] |=>
		o_prio.in_cap_three_prio
		== $past(i_avs_writedata[FLD_LOW +: FLD_W]))
		else $error("capture three field misplaced");

	cmp5_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_10
		&& lane_mask[FLD_LOW] |=>
		o_prio.out_cmp_five_prio
		== $past(i_avs_writedata[FLD_LOW +: FLD_W]))
		else $error("compare five field misplaced");

	port_field_a: assert property (@(posedge i_clk)
		disable iff (i_rst)
		wr_fire && i_avs_address == OFF_PRIO_11
		&& lane_mask[FLD_LOW] |=>
		o_prio.parallel_port_prio
		== $past(i_avs_writedata[FLD_LOW +: FLD_W]))
		else $error("parallel port field misplaced");

endmodule

// ---- bench/test_ipr_regs.sv ----
// Self-checking bench for the interrupt priority register bank.
`timescale 1ns/1ps

module test_ipr_regs
	import ipr_pkg::*;
;
	logic               i_clk;
	logic               i_rst;
	ipr_addr_t          i_avs_address;
	logic               i_avs_read;
	logic               i_avs_write;
	logic [DATA_W-1:0]  i_avs_writedata;
	logic [BE_W-1:0]    i_avs_byteenable;
	logic [DATA_W-1:0]  o_avs_readdata;
	logic               o_avs_waitrequest;
	ipr_prio_t          o_prio;
	logic [NUM_SRC-1:0] o_src_active;
	logic [31:0]        lfsr;
	logic [15:0]        shadow [7];
	logic [31:0]        exp_q [$];
	int                 error_cnt;
	int                 samples_checked;

	// Layout kept apart from the package so a wrong table there shows up.
	localparam logic [15:0] IMPL [7] = '{16'h0007, 16'h7770, 16'h7777,
		16'h0077, 16'h7770, 16'h0070, 16'h0070};
	localparam int SREG [15] = '{0, 1, 1, 1, 2, 2, 2, 2,
		3, 3, 4, 4, 4, 5, 6};
	localparam int SLSB [15] = '{0, 12, 8, 4, 12, 8, 4, 0,
		4, 0, 12, 8, 4, 4, 4};

	ipr_regs uut (
		.i_clk            (i_clk),
		.i_rst            (i_rst),
		.i_avs_address    (i_avs_address),
		.i_avs_read       (i_avs_read),
		.i_avs_write      (i_avs_write),
		.i_avs_writedata  (i_avs_writedata),
		.i_avs_byteenable (i_avs_byteenable),
		.o_avs_readdata   (o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.o_prio           (o_prio),
		.o_src_active     (o_src_active)
	);

	always #5 i_clk = ~i_clk;

	// ************************************************************
	// Checking
	// ************************************************************
	task automatic check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	always @(posedge i_clk) begin
		if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
			check("readdata", o_avs_readdata, exp_q.pop_front());
		end
	end

	task automatic check_prio();
		logic [2:0] lvl;
		for (int s = 0; s < 15; s++) begin
			lvl = shadow[SREG[s]][SLSB[s] +: 3];
			check("prio", 32'(o_prio[s*3 +: 3]), 32'(lvl));
			check("active", 32'(o_src_active[s]), 32'(|lvl));
		end
	endtask

	task automatic close_out();
		$display("checks %0d, errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ************************************************************
	// Bus master
	// ************************************************************
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic access(input logic wr, input ipr_addr_t a,
		input logic [31:0] d, input logic [3:0] be);
		int waits;
		waits = 0;
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_write <= wr;
		i_avs_read <= ~wr;
		i_avs_writedata <= d;
		i_avs_byteenable <= be;
		@(posedge i_clk);
		while (o_avs_waitrequest !== 1'b0) begin
			waits++;
			@(posedge i_clk);
		end
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		check("waits", 32'(waits), 32'h1);
	endtask

	task automatic wr_reg(input int r, input logic [31:0] d,
		input logic [3:0] be);
		logic [15:0] m;
		m = IMPL[r] & {{8{be[1]}}, {8{be[0]}}};
		access(1'b1, REG_OFF[r], d, be);
		shadow[r] = (shadow[r] & ~m) | (d[15:0] & m);
		#1 check_prio();
	endtask

	task automatic rd_reg(input int r);
		lfsr = lfsr_next(lfsr);
		exp_q.push_back({16'h0, shadow[r]});
		access(1'b0, REG_OFF[r], lfsr, lfsr[3:0]);
	endtask

	task automatic reset_dut();
		i_rst <= 1'b1;
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		for (int r = 0; r < 7; r++) shadow[r] = 16'h4444 & IMPL[r];
		@(posedge i_clk);
		#1 check_prio();
		for (int r = 0; r < 7; r++) rd_reg(r);
	endtask

	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		i_clk = 1'b0;
		i_rst = 1'b1;
		i_avs_address = '0;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = '0;
		i_avs_byteenable = '0;
		lfsr = 32'h61b9;
		error_cnt = 0;
		samples_checked = 0;
		reset_dut();
		// Every field off, then every field at the top level.
		for (int r = 0; r < 7; r++) wr_reg(r, 32'h0, 4'hf);
		for (int r = 0; r < 7; r++) wr_reg(r, 32'hffffffff, 4'hf);
		for (int r = 0; r < 7; r++) rd_reg(r);
		// An unmapped word must neither store nor disturb the fields.
		access(1'b1, 5'h1c, 32'h0, 4'hf);
		exp_q.push_back(32'h0);
		access(1'b0, 5'h1c, 32'hffffffff, 4'hf);
		#1 check_prio();
		repeat (60) begin
			lfsr = lfsr_next(lfsr);
			wr_reg(int'(lfsr[15:8]) % 7, lfsr, lfsr[19:16]);
			rd_reg(int'(lfsr[15:8]) % 7);
		end
		reset_dut();
		repeat (3) @(posedge i_clk);
		check("queue", 32'(exp_q.size()), 32'h0);
		close_out();
	end

	initial begin
		repeat (5000) @(posedge i_clk);
		error_cnt++;
		close_out();
	end
endmodule
